// ==== slsw_pkg.sv ====
// Notes on behaviour
// R01 - while any stop mode is active the interface gets no clock, so none of its state advances; the edge flag and irq still update in shallow stop.
// R02 - entering either deep stop mode wipes every register, and software must set everything up again.
// R03 - in shallow stop no register changes, so configuration and status are kept intact; the code still lets the edge flag set in shallow stop.
// R04 - in shallow stop, and only there, the receive-edge detector keeps running, and an edge wakes the CPU if its interrupt enable is 1.
// R05 - after shallow stop the interface carries on from the state it held, because nothing was reset.
// R06 - software should not enter stop while a character is still being shifted in or out.
// R07 - with loop enable set, receiver source 0 selects internal loop mode and 1 selects single-wire mode.
// R08 - in internal loop mode the transmitter output feeds the receiver, and the receive pin is handed back to the port.
// R09 - in single-wire mode the receiver listens to the transmitter output and the transmit pin, and the receive pin is released.
// R10 - in single-wire mode with direction 0, the transmit pin is an input and the transmitter is cut off from it.
// R11 - in single-wire mode with direction 1, the transmitter drives the transmit pin as an output.
// R12 - in single-wire mode the receiver also receives every character that the transmitter sends; the code does so only with direction 1.
// R13 - the direction bit is bit 5 of the third control register and acts only when loop enable and receiver source are both set.
// R14 - the edge interrupt enable is bit 6 of the baud-rate high register, and while it is set an interrupt is requested whenever the edge flag is 1.
// R15 - stop inputs tell deep stop apart from shallow stop; deep stop resets every register, shallow stop only freezes them; the code lets the edge flag set.
package slsw_pkg;
   localparam logic [7:0] SLSW_BAUD_HIGH_OFF = 8'h00;
   localparam logic [7:0] SLSW_CTRL_THREE_OFF = 8'h04;
   localparam logic [7:0] SLSW_IRQ_STATUS_OFF = 8'h08;
   localparam logic [7:0] SLSW_IRQ_ENABLE_OFF = 8'h0c;
   localparam logic [7:0] SLSW_IRQ_CLEAR_OFF = 8'h10;
   localparam logic [7:0] SLSW_MODE_OFF = 8'h14;
   localparam logic [7:0] SLSW_LINE_OFF = 8'h18;
   localparam int SLSW_EDGE_IE_BIT = 6;
   localparam int SLSW_TX_DIR_BIT = 5;
   localparam int SLSW_LOOP_BIT = 0;
   localparam int SLSW_RECEIVER_SOURCE_SELECT_BIT = 1;
   localparam logic [7:0] SLSW_BAUD_HIGH_RST = 8'h00;
   localparam logic [7:0] SLSW_CTRL_THREE_RST = 8'h00;
   localparam logic [1:0] SLSW_MODE_RST = 2'h0;
   localparam logic [1:0] SLSW_RESP_OKAY = 2'h0;
   localparam logic [1:0] SLSW_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SLSW_RUN = 3'b001,
      SLSW_SHALLOW = 3'b010,
      SLSW_DEEP = 3'b100
   } slsw_power_e;

   typedef struct packed {
      logic loop_enable;
      logic receiver_source_select;
      logic transmit_pin_direction;
   } slsw_route_s;

   typedef struct packed {
      logic tx_pin_out;
      logic tx_pin_oe;
      logic rx_to_receiver;
      logic rx_pin_released;
   } slsw_pins_s;
endpackage

// ==== slsw_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module slsw_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic aclken,
   input wire logic d,
   output logic q
);
   logic meta_ff;
   // ignores stop so the edge detector still sees the pin; aclken freezes it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_ff <= 1'b1;
         q <= 1'b1;
      end else if (aclken) begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule // slsw_sync
`default_nettype wire

// ==== slsw_core.sv ====
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module slsw_core (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic aclken,
   input wire logic shallow_stop,
   input wire logic deep_stop_one,
   input wire logic deep_stop_two,
   input wire logic tx_serial,
   input wire logic tx_pin_in,
   input wire logic rx_pin_in,
   output logic tx_pin_out,
   output logic tx_pin_oe,
   output logic rx_serial,
   output logic rx_pin_released,
   output logic wake_req,
   output logic irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic tx_pin_s, rx_pin_s;
   logic deep_stop, any_stop, run;
   logic [7:0] baud_high_ff;
   logic [7:0] ctrl_three_ff;
   logic edge_flag_ff;
   logic edge_en_ff;
   logic rx_prev_ff;
   logic aw_got_ff, w_got_ff;
   logic [7:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic do_write;
   logic clr_edge;
   logic rx_source;
   logic edge_seen;
   slsw_pkg::slsw_power_e power_ff;
   slsw_pkg::slsw_power_e nxt_power;
   slsw_pkg::slsw_route_s route;
   slsw_pkg::slsw_pins_s nxt_pins;
   logic [31:0] nxt_rdata;
   logic [1:0] nxt_rresp;

   slsw_sync u_sync_tx (
      .aclk(aclk),
      .aresetn(aresetn),
      .aclken(aclken),
      .d(tx_pin_in),
      .q(tx_pin_s)
   );

   slsw_sync u_sync_rx (
      .aclk(aclk),
      .aresetn(aresetn),
      .aclken(aclken),
      .d(rx_pin_in),
      .q(rx_pin_s)
   );

   assign deep_stop = deep_stop_one | deep_stop_two;
   assign any_stop = deep_stop | shallow_stop;
   // bus clock halts in every stop mode; aclken gates all state as well
   assign run = aclken & ~any_stop; // R01

   always_comb begin
      nxt_power = slsw_pkg::SLSW_RUN;
      if (deep_stop) begin
         nxt_power = slsw_pkg::SLSW_DEEP;
      end else if (shallow_stop) begin
         nxt_power = slsw_pkg::SLSW_SHALLOW;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_ff <= slsw_pkg::SLSW_RUN;
      end else if (aclken) begin
         power_ff <= nxt_power;
      end
   end

   assign route.loop_enable = ctrl_three_ff[slsw_pkg::SLSW_LOOP_BIT];
   assign route.receiver_source_select = ctrl_three_ff[slsw_pkg::SLSW_RECEIVER_SOURCE_SELECT_BIT];
   // direction bit matters only in single-wire mode
   assign route.transmit_pin_direction = ctrl_three_ff[slsw_pkg::SLSW_TX_DIR_BIT]; // R13

   always_comb begin
      nxt_pins.tx_pin_out = tx_serial;
      nxt_pins.tx_pin_oe = 1'b1;
      nxt_pins.rx_to_receiver = rx_pin_s;
      nxt_pins.rx_pin_released = 1'b0;
      if (route.loop_enable && !route.receiver_source_select) begin // R07
         nxt_pins.rx_to_receiver = tx_serial; // R08
         nxt_pins.rx_pin_released = 1'b1; // R08
      end else if (route.loop_enable && route.receiver_source_select) begin // R07
         nxt_pins.rx_pin_released = 1'b1; // R09
         if (route.transmit_pin_direction) begin
            nxt_pins.tx_pin_oe = 1'b1; // R11
            nxt_pins.rx_to_receiver = tx_serial; // R12
         end else begin
            nxt_pins.tx_pin_oe = 1'b0; // R10
            nxt_pins.rx_to_receiver = tx_pin_s; // R10
         end
      end
   end

   // pin drive freezes with the rest in stop; deep stop returns it to reset
   always_ff @(posedge aclk) begin
      if (!aresetn || (aclken && deep_stop)) begin
         tx_pin_out <= 1'b1;
         tx_pin_oe <= 1'b0;
         rx_serial <= 1'b1;
         rx_pin_released <= 1'b0;
      end else if (run) begin
         tx_pin_out <= nxt_pins.tx_pin_out;
         tx_pin_oe <= nxt_pins.tx_pin_oe;
         rx_serial <= nxt_pins.rx_to_receiver;
         rx_pin_released <= nxt_pins.rx_pin_released;
      end
   end

   // edge detector samples the receive source even in shallow stop
   assign rx_source = nxt_pins.rx_to_receiver;
   assign edge_seen = rx_prev_ff & ~rx_source;

   always_ff @(posedge aclk) begin
      if (!aresetn || (aclken && deep_stop)) begin
         rx_prev_ff <= 1'b1;
      end else if (aclken) begin
         rx_prev_ff <= rx_source; // R04
      end
   end

   // deep stop wipes all registers
   always_ff @(posedge aclk) begin
      if (!aresetn || (aclken && deep_stop)) begin // R02 R15
         baud_high_ff <= slsw_pkg::SLSW_BAUD_HIGH_RST;
         ctrl_three_ff <= slsw_pkg::SLSW_CTRL_THREE_RST;
         edge_en_ff <= 1'b0;
      end else if (run && do_write) begin // R03 R05
         if (aw_addr_ff == slsw_pkg::SLSW_BAUD_HIGH_OFF && w_strb_ff[0]) begin
            baud_high_ff <= w_data_ff[7:0];
         end
         if (aw_addr_ff == slsw_pkg::SLSW_CTRL_THREE_OFF && w_strb_ff[0]) begin
            ctrl_three_ff <= w_data_ff[7:0];
         end
         if (aw_addr_ff == slsw_pkg::SLSW_IRQ_ENABLE_OFF && w_strb_ff[0]) begin
            edge_en_ff <= w_data_ff[0];
         end
      end
   end

   assign clr_edge = do_write && w_strb_ff[0] && w_data_ff[0]
      && aw_addr_ff == slsw_pkg::SLSW_IRQ_CLEAR_OFF;

   // edge flag, irq and wake_req still change in shallow stop; set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn || (aclken && deep_stop)) begin // R02 R15
         edge_flag_ff <= 1'b0;
      end else if (aclken && edge_seen && !deep_stop) begin
         edge_flag_ff <= 1'b1; // R04
      end else if (run && clr_edge) begin
         edge_flag_ff <= 1'b0;
      end
   end

   // irq gated by either enable copy; wake only from shallow stop
   always_ff @(posedge aclk) begin
      if (!aresetn || (aclken && deep_stop)) begin
         irq <= 1'b0;
         wake_req <= 1'b0;
      end else if (aclken) begin
         irq <= edge_flag_ff & (baud_high_ff[slsw_pkg::SLSW_EDGE_IE_BIT] | edge_en_ff); // R14
         wake_req <= edge_flag_ff & baud_high_ff[slsw_pkg::SLSW_EDGE_IE_BIT]
            & (power_ff == slsw_pkg::SLSW_SHALLOW); // R04
      end
   end

   // software is expected to idle the line before stop
   assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid; // R06

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= slsw_pkg::SLSW_RESP_OKAY;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (run) begin
         s_axi_awready <= !aw_got_ff && !s_axi_awready;
         s_axi_wready <= !w_got_ff && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_ff <= slsw_pkg::SLSW_LINE_OFF && aw_addr_ff[1:0] == 2'h0
               && aw_addr_ff != slsw_pkg::SLSW_IRQ_STATUS_OFF)
               ? slsw_pkg::SLSW_RESP_OKAY : slsw_pkg::SLSW_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = slsw_pkg::SLSW_RESP_OKAY;
      case (s_axi_araddr)
         slsw_pkg::SLSW_BAUD_HIGH_OFF: nxt_rdata[7:0] = baud_high_ff;
         slsw_pkg::SLSW_CTRL_THREE_OFF: nxt_rdata[7:0] = ctrl_three_ff;
         slsw_pkg::SLSW_IRQ_STATUS_OFF: nxt_rdata[0] = edge_flag_ff;
         slsw_pkg::SLSW_IRQ_ENABLE_OFF: nxt_rdata[0] = edge_en_ff;
         slsw_pkg::SLSW_IRQ_CLEAR_OFF: nxt_rdata = 32'h0000_0000;
         slsw_pkg::SLSW_MODE_OFF: nxt_rdata[2:0] = power_ff;
         slsw_pkg::SLSW_LINE_OFF: nxt_rdata[3:0] = {tx_pin_oe, rx_pin_released,
            rx_serial, tx_pin_out};
         default: nxt_rresp = slsw_pkg::SLSW_RESP_SLVERR;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= slsw_pkg::SLSW_RESP_OKAY;
      end else if (run) begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= nxt_rdata;
            s_axi_rresp <= nxt_rresp;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // slsw_core
`default_nettype wire

// ==== slsw_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module slsw_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic aclken,
   input wire logic shallow_stop,
   input wire logic deep_stop_one,
   input wire logic deep_stop_two,
   input wire logic tx_serial,
   input wire logic tx_pin_out,
   input wire logic tx_pin_oe,
   input wire logic rx_serial,
   input wire logic rx_pin_released,
   input wire logic wake_req,
   input wire logic irq,
   input wire logic s_axi_awready
);
   logic run;
   assign run = aclken && !shallow_stop && !deep_stop_one && !deep_stop_two;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_deep;
      (deep_stop_one || deep_stop_two) && aclken;
   endsequence
   sequence s_shallow;
      shallow_stop && aclken && !deep_stop_one && !deep_stop_two;
   endsequence
   a_halt_freezes: assert property (!aclken |=> $stable(rx_serial) && $stable(irq))
      else $error("state moved with clock held");
   a_bus_stays_idle: assert property ($rose(s_axi_awready) |-> $past(run))
      else $error("bus ready rose during stop");
   a_deep_wipes: assert property (s_deep |=> !irq && !wake_req && !tx_pin_oe && rx_serial)
      else $error("deep stop left state behind");
   a_shallow_holds: assert property (s_shallow |=> $stable(tx_pin_oe) && $stable(rx_serial)
      && $stable(rx_pin_released) && $stable(s_axi_awready))
      else $error("state changed in shallow stop");
   a_wake_shallow_only: assert property (wake_req |-> $past(shallow_stop, 2))
      else $error("wake outside shallow stop");
   a_wake_has_irq: assert property (wake_req |-> irq)
      else $error("wake without interrupt");
   a_loop_feeds_rx: assert property (rx_pin_released && tx_pin_oe && $past(run)
      |-> rx_serial == $past(tx_serial))
      else $error("receiver not fed by transmitter");
   a_pin_follows_tx: assert property (tx_pin_oe && $past(run) |-> tx_pin_out == $past(tx_serial))
      else $error("driven pin differs from transmitter");
endmodule // slsw_properties
bind slsw_core slsw_properties u_props (.aclk, .aresetn, .aclken, .shallow_stop, .deep_stop_one,
   .deep_stop_two, .tx_serial, .tx_pin_out, .tx_pin_oe, .rx_serial, .rx_pin_released,
   .wake_req, .irq, .s_axi_awready);
`default_nettype wire

// ==== slsw_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module slsw_partner #(parameter int BIT_CYC = 8) (
   input wire logic aclk,
   input wire logic go,
   input wire logic [7:0] data,
   output logic line_en,
   output logic line_drv
);
   int cnt = 0;
   logic [9:0] frame = 10'h3ff;
   // drives only within a frame, the pull-up owns the idle line
   assign line_en = (cnt != 0);
   assign line_drv = frame[(10 * BIT_CYC - cnt) / BIT_CYC];
   always @(posedge aclk) begin
      if (go && cnt == 0) begin
         frame <= {1'h1, data, 1'h0};
         cnt <= 10 * BIT_CYC;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule // slsw_partner
`default_nettype wire

// ==== sci_loop_single_wire_stop_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module sci_loop_single_wire_stop_test;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic aclken = 1'h1;
   logic shallow_stop = 1'h0;
   logic deep_stop_one = 1'h0;
   logic deep_stop_two = 1'h0;
   logic tx_serial = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h1;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h1;
   logic go = 1'h0;
   logic use_tx = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic tx_pin_out, tx_pin_oe, rx_serial, rx_pin_released, wake_req, irq, p_en, p_drv;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd;
   wire tx_wire;
   wire rx_wire;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [7:0] mv [4] = '{8'h01, 8'h21, 8'h23, 8'h03};
   logic [3:0] eoe = 4'h7;
   logic [3:0] erx = 4'h8;
   always #2 aclk = ~aclk;
   assign tx_wire = tx_pin_oe ? tx_pin_out : (p_en && use_tx ? p_drv : 1'h1);
   assign rx_wire = p_en && !use_tx ? p_drv : 1'h1;
   slsw_partner #(.BIT_CYC(8)) peer (.aclk, .go, .data(8'h55), .line_en(p_en), .line_drv(p_drv));
   slsw_core uut (.aclk, .aresetn, .aclken, .shallow_stop, .deep_stop_one, .deep_stop_two,
      .tx_serial, .tx_pin_in(tx_wire), .rx_pin_in(rx_wire), .tx_pin_out, .tx_pin_oe, .rx_serial,
      .rx_pin_released, .wake_req, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      resp = s_axi_bresp;
   endtask
   task automatic rdr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
      rdr(a);
      `CHK(nm, ex, rd)
   endtask
   task automatic send(input logic pin);
      use_tx <= pin;
      go <= 1'h1;
      @(posedge aclk);
      go <= 1'h0;
   endtask
   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rchk("baud", slsw_pkg::SLSW_BAUD_HIGH_OFF, 32'h0);
      rchk("mode", slsw_pkg::SLSW_MODE_OFF, 32'h1);
      rdr(8'h40);
      `CHK("unmapped", slsw_pkg::SLSW_RESP_SLVERR, resp)
      wr(slsw_pkg::SLSW_IRQ_STATUS_OFF, 32'h1);
      `CHK("ro_write", slsw_pkg::SLSW_RESP_SLVERR, resp)
      send(1'h0);
      repeat (4) @(posedge aclk);
      `CHK("rx_pin", 1'h0, rx_serial)
      repeat (85) @(posedge aclk);
      rchk("flag", slsw_pkg::SLSW_IRQ_STATUS_OFF, 32'h1);
      wr(slsw_pkg::SLSW_IRQ_ENABLE_OFF, 32'h1);
      @(posedge aclk);
      `CHK("irq_on", 1'h1, irq)
      wr(slsw_pkg::SLSW_IRQ_ENABLE_OFF, 32'h0);
      @(posedge aclk);
      `CHK("irq_mask", 1'h0, irq)
      wr(slsw_pkg::SLSW_BAUD_HIGH_OFF, 32'h40);
      @(posedge aclk);
      `CHK("irq_edge_ie", 1'h1, irq)
      wr(slsw_pkg::SLSW_IRQ_CLEAR_OFF, 32'h1);
      @(posedge aclk);
      `CHK("irq_clr", 1'h0, irq)
      for (int i = 0; i < 4; i++) begin
         wr(slsw_pkg::SLSW_CTRL_THREE_OFF, {24'h0, mv[i]});
         tx_serial <= 1'h0;
         repeat (4) @(posedge aclk);
         `CHK("released", 1'h1, rx_pin_released)
         `CHK("pin_oe", eoe[i], tx_pin_oe)
         `CHK("tx_pin", !eoe[i], tx_wire)
         `CHK("rx_src", erx[i], rx_serial)
         tx_serial <= 1'h1;
      end
      send(1'h1);
      repeat (4) @(posedge aclk);
      `CHK("tx_pin_in", 1'h0, rx_serial)
      repeat (85) @(posedge aclk);
      wr(slsw_pkg::SLSW_CTRL_THREE_OFF, 32'h23);
      aclken <= 1'h0;
      tx_serial <= 1'h0;
      repeat (5) @(posedge aclk);
      `CHK("halted", 1'h1, rx_serial)
      aclken <= 1'h1;
      repeat (3) @(posedge aclk);
      `CHK("resumed", 1'h0, rx_serial)
      tx_serial <= 1'h1;
      wr(slsw_pkg::SLSW_CTRL_THREE_OFF, 32'h0);
      wr(slsw_pkg::SLSW_IRQ_CLEAR_OFF, 32'h1);
      rchk("line_idle", slsw_pkg::SLSW_LINE_OFF, 32'hb);
      // transmitter idle before any stop
      shallow_stop <= 1'h1;
      repeat (3) @(posedge aclk);
      send(1'h0);
      for (int n = 0; n < 40 && wake_req !== 1'h1; n++) @(posedge aclk);
      `CHK("wake", 1'h1, wake_req)
      repeat (85) @(posedge aclk);
      shallow_stop <= 1'h0;
      @(posedge aclk);
      rchk("kept_baud", slsw_pkg::SLSW_BAUD_HIGH_OFF, 32'h40);
      rchk("kept_flag", slsw_pkg::SLSW_IRQ_STATUS_OFF, 32'h1);
      deep_stop_two <= 1'h1;
      repeat (2) @(posedge aclk);
      send(1'h0);
      repeat (20) @(posedge aclk);
      `CHK("no_wake", 1'h0, wake_req)
      repeat (70) @(posedge aclk);
      deep_stop_two <= 1'h0;
      @(posedge aclk);
      rchk("lost_baud", slsw_pkg::SLSW_BAUD_HIGH_OFF, 32'h0);
      wr(slsw_pkg::SLSW_CTRL_THREE_OFF, 32'h23);
      deep_stop_one <= 1'h1;
      repeat (3) @(posedge aclk);
      deep_stop_one <= 1'h0;
      @(posedge aclk);
      rchk("lost_ctrl", slsw_pkg::SLSW_CTRL_THREE_OFF, 32'h0);
      tally_and_finish();
   end
endmodule // sci_loop_single_wire_stop_test
`default_nettype wire
